// ### hbc_pkg.sv
package hbc_pkg;
  // Timing at 200 MHz, 5 ns period.
  localparam int CLK_PERIOD_PS        = 5000;
  localparam int LIMIT_OFF_TIME_NS    = 20000;
  localparam int SHORT_BLANK_TIME_NS  = 16500;
  localparam int LIMIT_OFF_CYCLES     = (LIMIT_OFF_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int SHORT_BLANK_CYCLES   = (SHORT_BLANK_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int TMR_W                = 16;
  // Controller register offsets.
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_IRQ_ST  = 12'h008;
  localparam logic [11:0] REG_IRQ_MSK = 12'h00c;
  // Field positions.
  localparam int CTRL_DIR_A           = 0;
  localparam int CTRL_DIR_B           = 1;
  localparam int CTRL_DIS_HI          = 2;
  localparam int CTRL_DIS_LO_N        = 3;
  localparam int IRQ_FAULT_SET        = 0;
  localparam int IRQ_FAULT_CLR        = 1;
  // Value after reset: bridge disabled by both inputs, directions low.
  localparam logic [3:0] CTRL_RESET   = 4'h4;
  localparam logic [1:0] IRQ_RESET    = 2'h0;
  typedef enum logic [1:0] {HBC_HIZ, HBC_FWD, HBC_REV, HBC_BRAKE} hbc_mode_e;
endpackage

// ### hbc_if.sv
`timescale 1ns/1ps
interface hbc_if;
  logic dir_in_a;
  logic dir_in_b;
  logic disable_hi;
  logic disable_lo_n;
  logic fault_flag_n_oe;
  logic fault_flag_n;
  logic bridge_out_a;
  logic bridge_out_b;
  logic bridge_oe;
  // Open-drain fault line with external pull-up.
  assign fault_flag_n = fault_flag_n_oe ? 1'b0 : 1'b1;
  modport device (
    input  dir_in_a, dir_in_b, disable_hi, disable_lo_n, fault_flag_n,
    output fault_flag_n_oe, bridge_out_a, bridge_out_b, bridge_oe
  );
  modport host (
    output dir_in_a, dir_in_b, disable_hi, disable_lo_n,
    input  fault_flag_n, fault_flag_n_oe, bridge_out_a, bridge_out_b, bridge_oe
  );
endinterface

// ### hbc_device.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Drive only when enabled, no fault, not in off-time.
// - Equal inputs brake on both high or low.
// - Each direction input drives its output true.
// - Either disable asserted tri-states both outputs.
// - Under-voltage tri-states, flags; recovers automatically.
// - Short circuit latches outputs off, flags.
// - Short latch cleared at run time only by disable edge.
// - Power cycle also clears latches; flag held low in reset.
// - Over-temperature latches outputs off, flags.
// - Re-enable after thermal reset needs hysteresis clear.
// - Current limit tri-states for fixed off-time.
// - Over-limit temperature trips.
// - Over-limit during blanking is a hard short.
// - Fault flag is open-drain, pulled low.
// - Disable asserted holds flag low.
module hbc_device
  import hbc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  hbc_if.device     pins,
  input  wire logic supply_ok,
  input  wire logic over_current,
  input  wire logic temp_over_trip,
  input  wire logic temp_below_hyst,
  output logic      short_latched,
  output logic      thermal_latched,
  output logic      limit_active
);
  import hbc_pkg::*;

  logic [3:0]       meta_q;
  logic [3:0]       sync_q;
  logic [3:0]       prev_q;
  logic             clear_edge;
  logic             enabled;
  logic             fault;
  logic             drive_en;
  logic             drive_en_q;
  logic             activation;
  logic [TMR_W-1:0] blank_q;
  logic [TMR_W-1:0] off_q;
  logic             thermal_hold_q;
  logic             out_a_q;
  logic             out_b_q;
  logic             oe_q;
  logic             flag_q;
  logic [3:0]       sense_meta_q;
  logic [3:0]       sense_q;
  logic             supply_ok_s;
  logic             over_current_s;
  logic             temp_over_trip_s;
  logic             temp_below_hyst_s;
  hbc_mode_e        mode;

  // Two-stage synchronisers on the four control pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= CTRL_RESET;
      sync_q <= CTRL_RESET;
      prev_q <= CTRL_RESET;
    end else begin
      meta_q <= {pins.disable_lo_n, pins.disable_hi, pins.dir_in_b, pins.dir_in_a};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Falling edge of disable_hi or rising edge of disable_lo_n.
  assign clear_edge = (prev_q[2] & ~sync_q[2]) | (~prev_q[3] & sync_q[3]);
  assign enabled    = ~sync_q[2] & sync_q[3];

  // The sensor levels come from the analog side, so they are resynchronised as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta_q <= '0;
      sense_q      <= '0;
    end else begin
      sense_meta_q <= {temp_below_hyst, temp_over_trip, over_current, supply_ok};
      sense_q      <= sense_meta_q;
    end
  end

  assign supply_ok_s       = sense_q[0];
  assign over_current_s    = sense_q[1];
  assign temp_over_trip_s  = sense_q[2];
  assign temp_below_hyst_s = sense_q[3];

  // Short-circuit latch, set by a hard short inside the blanking window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_latched <= 1'b0;
    end else if (oe_q && over_current_s && blank_q != '0) begin
      short_latched <= 1'b1;
    end else if (clear_edge) begin
      short_latched <= 1'b0;
    end
  end

  // Thermal latch; after a clear, drive waits for the hysteresis point.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_latched <= 1'b0;
      thermal_hold_q  <= 1'b0;
    end else begin
      if (temp_over_trip_s) begin
        thermal_latched <= 1'b1;
      end else if (clear_edge) begin
        thermal_latched <= 1'b0;
      end
      if (temp_over_trip_s) begin
        thermal_hold_q <= 1'b1;
      end else if (temp_below_hyst_s) begin
        thermal_hold_q <= 1'b0;
      end
    end
  end

  assign fault      = short_latched | thermal_latched | thermal_hold_q | ~supply_ok_s;
  assign drive_en   = enabled & ~fault & (off_q == '0);
  assign activation = drive_en & ~drive_en_q;

  // Blanking timer restarts on every activation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_en_q <= 1'b0;
      blank_q    <= '0;
    end else begin
      drive_en_q <= drive_en;
      if (activation) begin
        blank_q <= TMR_W'(SHORT_BLANK_CYCLES);
      end else if (blank_q != '0) begin
        blank_q <= blank_q - 1'b1;
      end
    end
  end

  // Constant off-time current limiting after the blanking window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_q <= '0;
    end else if (off_q != '0) begin
      off_q <= off_q - 1'b1;
    end else if (oe_q && over_current_s && blank_q == '0) begin
      off_q <= TMR_W'(LIMIT_OFF_CYCLES);
    end
  end
  assign limit_active = off_q != '0;

  // Bridge state from drive permission and the two direction levels.
  function automatic hbc_mode_e decode_mode(input logic drive,
                                            input logic dir_a,
                                            input logic dir_b);
    hbc_mode_e m;
    if (!drive) begin
      m = HBC_HIZ;
    end else if (dir_a == dir_b) begin
      m = HBC_BRAKE;
    end else if (dir_a) begin
      m = HBC_FWD;
    end else begin
      m = HBC_REV;
    end
    return m;
  endfunction

  assign mode = decode_mode(drive_en, sync_q[0], sync_q[1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      unique case (mode)
        HBC_HIZ: begin
          out_a_q <= 1'b0;
          out_b_q <= 1'b0;
        end
        HBC_FWD: begin
          out_a_q <= 1'b1;
          out_b_q <= 1'b0;
        end
        HBC_REV: begin
          out_a_q <= 1'b0;
          out_b_q <= 1'b1;
        end
        HBC_BRAKE: begin
          out_a_q <= sync_q[0];
          out_b_q <= sync_q[1];
        end
      endcase
      oe_q <= mode != HBC_HIZ;
    end
  end

  // Flag low on any fault or disable; current limiting is not a fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b1;
    end else begin
      flag_q <= fault | ~enabled;
    end
  end

  assign pins.bridge_out_a    = out_a_q;
  assign pins.bridge_out_b    = out_b_q;
  assign pins.bridge_oe       = oe_q;
  assign pins.fault_flag_n_oe = flag_q;
endmodule // hbc_device

// ### hbc_host.sv
`timescale 1ns/1ps
module hbc_host
  import hbc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  hbc_if.host              pins,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import hbc_pkg::*;

  logic [3:0] ctrl_q;
  logic [1:0] irq_st_q;
  logic [1:0] irq_msk_q;
  logic       flag_meta_q;
  logic       flag_sync_q;
  logic       flag_prev_q;
  logic       wr;
  logic [1:0] ev;

  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr && paddr == REG_CTRL) begin
      ctrl_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // The device holds its flag low through reset, so no false edge follows reset.
      flag_meta_q <= 1'b0;
      flag_sync_q <= 1'b0;
      flag_prev_q <= 1'b0;
    end else begin
      flag_meta_q <= pins.fault_flag_n;
      flag_sync_q <= flag_meta_q;
      flag_prev_q <= flag_sync_q;
    end
  end

  assign ev = {~flag_prev_q & flag_sync_q, flag_prev_q & ~flag_sync_q};

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q  <= IRQ_RESET;
      irq_msk_q <= IRQ_RESET;
    end else begin
      if (wr && paddr == REG_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~pwdata[1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (wr && paddr == REG_IRQ_MSK) begin
        irq_msk_q <= pwdata[1:0];
      end
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        REG_CTRL:    prdata <= {28'h0, ctrl_q};
        REG_STATUS:  prdata <= {29'h0, pins.bridge_oe, flag_sync_q, pins.bridge_oe};
        REG_IRQ_ST:  prdata <= {30'h0, irq_st_q};
        REG_IRQ_MSK: prdata <= {30'h0, irq_msk_q};
        default:     prdata <= '0;
      endcase
    end
  end

  assign pins.dir_in_a     = ctrl_q[CTRL_DIR_A];
  assign pins.dir_in_b     = ctrl_q[CTRL_DIR_B];
  assign pins.disable_hi   = ctrl_q[CTRL_DIS_HI];
  assign pins.disable_lo_n = ctrl_q[CTRL_DIS_LO_N];
endmodule // hbc_host

// ### hbc_monitor.sv
`timescale 1ns/1ps
module hbc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dir_in_a,
  input wire logic dir_in_b,
  input wire logic disable_hi,
  input wire logic disable_lo_n,
  input wire logic fault_flag_n_oe,
  input wire logic fault_flag_n,
  input wire logic bridge_out_a,
  input wire logic bridge_out_b,
  input wire logic bridge_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_hi_hiz: assert property (disable_hi [*5] |-> !bridge_oe)
    else $error("bridge driven while disable_hi high");
  chk_lo_hiz: assert property (!disable_lo_n [*5] |-> !bridge_oe)
    else $error("bridge driven while disable_lo_n low");
  chk_hi_flag: assert property (disable_hi [*5] |-> fault_flag_n_oe)
    else $error("flag released while disable_hi high");
  chk_lo_flag: assert property (!disable_lo_n [*5] |-> fault_flag_n_oe)
    else $error("flag released while disable_lo_n low");
  chk_fault_hiz: assert property (bridge_oe |-> !fault_flag_n_oe)
    else $error("bridge driven while flag low");
  chk_flag_release: assert property ($fell(fault_flag_n_oe) |-> !disable_hi && disable_lo_n)
    else $error("flag released with a disable asserted");
  chk_oe_rise: assert property ($rose(bridge_oe) |->
    !$past(disable_hi, 2) && $past(disable_lo_n, 2))
    else $error("bridge enabled without both disables clear");
  chk_out_true: assert property (($stable(dir_in_a) && $stable(dir_in_b)) [*5] ##0 bridge_oe
    |-> bridge_out_a == dir_in_a && bridge_out_b == dir_in_b)
    else $error("bridge outputs differ from direction inputs");
  cover property ($fell(fault_flag_n));
  cover property (bridge_oe && dir_in_a != dir_in_b);
  cover property (bridge_oe && dir_in_a == dir_in_b);
endmodule // hbc_monitor

// ### hbc_tb_top.sv
`timescale 1ns/1ps
module hbc_tb_top;
  import hbc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, irq0, short_latched, thermal_latched, limit_active;
  logic        supply_ok = 1'b1, over_current = 1'b0, temp_over_trip = 1'b0;
  logic        temp_below_hyst = 1'b1;
  int          n_fail = 0, n_checks = 0;
  hbc_if hbc_if_inst ();
  always #2.5 pclk = ~pclk;
  hbc_device hbc_device_inst (.pclk, .presetn, .pins(hbc_if_inst.device), .supply_ok,
    .over_current, .temp_over_trip, .temp_below_hyst, .short_latched, .thermal_latched,
    .limit_active);
  hbc_host hbc_host_inst (.pclk, .presetn, .pins(hbc_if_inst.host), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  hbc_monitor hbc_monitor_inst (.pclk, .presetn, .dir_in_a(hbc_if_inst.dir_in_a),
    .dir_in_b(hbc_if_inst.dir_in_b), .disable_hi(hbc_if_inst.disable_hi),
    .disable_lo_n(hbc_if_inst.disable_lo_n), .fault_flag_n_oe(hbc_if_inst.fault_flag_n_oe),
    .fault_flag_n(hbc_if_inst.fault_flag_n), .bridge_out_a(hbc_if_inst.bridge_out_a),
    .bridge_out_b(hbc_if_inst.bridge_out_b), .bridge_oe(hbc_if_inst.bridge_oe));
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Output levels are only meaningful while the bridge drives.
  task automatic chk_pins(input logic oe, input logic fl, input logic [1:0] o);
    chk("bridge_oe", {31'h0, oe}, {31'h0, hbc_if_inst.bridge_oe});
    chk("fault_flag_n", {31'h0, fl}, {31'h0, hbc_if_inst.fault_flag_n});
    if (oe) chk("bridge_out", {30'h0, o},
                {30'h0, hbc_if_inst.bridge_out_b, hbc_if_inst.bridge_out_a});
  endtask
  task automatic ctrl(input logic [3:0] v);
    apb(1'b1, REG_CTRL, {28'h0, v});
    wait_n(6);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    wait_n(40000);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    wait_n(10);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_reset", {28'h0, CTRL_RESET}, rd);
    wait_n(4);
    chk_pins(1'b0, 1'b0, 2'b00);
    for (int i = 0; i < 4; i++) begin
      ctrl(4'h8 | i[3:0]);
      chk_pins(1'b1, 1'b1, i[1:0]);
    end
    ctrl(4'hd);
    chk_pins(1'b0, 1'b0, 2'b00);
    ctrl(4'h1);
    chk_pins(1'b0, 1'b0, 2'b00);
    apb(1'b1, REG_IRQ_ST, 32'h3);
    ctrl(4'h9);
    over_current <= 1'b1;
    wait_n(6);
    over_current <= 1'b0;
    chk_pins(1'b0, 1'b0, 2'b00);
    chk("short", 32'h1, {31'h0, short_latched});
    ctrl(4'ha);
    chk_pins(1'b0, 1'b0, 2'b00);
    apb(1'b0, REG_IRQ_ST, 32'h0);
    chk("irq_status", 32'h3, rd & 32'h3);
    apb(1'b1, REG_IRQ_MSK, 32'h0);
    wait_n(2);
    irq0 = irq;
    apb(1'b1, REG_IRQ_MSK, 32'h3);
    wait_n(2);
    chk("irq_masked", 32'h0, {31'h0, irq0});
    chk("irq_mask", 32'h1, {31'h0, irq});
    apb(1'b1, REG_IRQ_ST, 32'h3);
    apb(1'b0, REG_IRQ_ST, 32'h0);
    chk("irq_clear", 32'h0, rd & 32'h3);
    chk("irq_low", 32'h0, {31'h0, irq});
    ctrl(4'hd);
    ctrl(4'h9);
    chk_pins(1'b1, 1'b1, 2'b01);
    chk("short_clear", 32'h0, {31'h0, short_latched});
    wait_n(3400);
    over_current <= 1'b1;
    wait_n(2);
    over_current <= 1'b0;
    wait_n(8);
    chk("limit", 32'h1, {31'h0, limit_active});
    chk_pins(1'b0, 1'b1, 2'b00);
    wait_n(3900);
    chk("off_time", 32'h0, {31'h0, hbc_if_inst.bridge_oe});
    wait_n(150);
    chk_pins(1'b1, 1'b1, 2'b01);
    temp_below_hyst <= 1'b0;
    temp_over_trip <= 1'b1;
    wait_n(6);
    temp_over_trip <= 1'b0;
    chk_pins(1'b0, 1'b0, 2'b00);
    chk("thermal", 32'h1, {31'h0, thermal_latched});
    ctrl(4'h1);
    ctrl(4'h9);
    chk("hyst_hold", 32'h0, {31'h0, hbc_if_inst.bridge_oe});
    temp_below_hyst <= 1'b1;
    wait_n(6);
    chk_pins(1'b1, 1'b1, 2'b01);
    supply_ok <= 1'b0;
    wait_n(6);
    chk_pins(1'b0, 1'b0, 2'b00);
    supply_ok <= 1'b1;
    wait_n(6);
    chk_pins(1'b1, 1'b1, 2'b01);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h7, rd);
    chk("pslverr", 32'h0, {31'h0, pslverr});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
    over_current <= 1'b1;
    wait_n(6);
    over_current <= 1'b0;
    chk("short_again", 32'h1, {31'h0, short_latched});
    presetn <= 1'b0;
    wait_n(2);
    presetn <= 1'b1;
    wait_n(2);
    chk("power_cycle", 32'h0, {31'h0, short_latched});
    tally_and_finish();
  end
endmodule // hbc_tb_top
